/* File: hw/smb_dev.sv */
`timescale 1ns/1ns
module smb_dev #(
  parameter int TIMEOUT_CYC = smb_pkg::TIMEOUT_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  smb_if.dev              bus,
  input  wire logic       address_strap_enable_pin_i,
  input  wire logic       address_select_strap_pin_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_we_o,
  input  wire logic [7:0] status_i,
  input  wire logic [7:0] mask_i,
  output logic            status_read_o,
  output logic [7:0]      cfg1_o,
  output logic            alert_n_o,
  output logic [6:0]      dev_addr_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WR   = 3'b011,
    ST_WACK = 3'b100,
    ST_RD   = 3'b101,
    ST_RACK = 3'b110
  } smb_dev_state_type;

  smb_dev_state_type state_q, state_d;
  logic [3:0]  bit_q;
  logic [7:0]  shift_q;
  logic [7:0]  ptr_q;
  logic [7:0]  cfg1_q;
  logic [6:0]  addr_q;
  logic        addr_set_q;
  logic        wr_cnt_q;
  logic        ara_q;
  logic        drive_q;
  logic        lost_q;
  logic        sda_oe_q;
  logic        we_q;
  logic [7:0]  wdata_q;
  logic [31:0] idle_q;
  logic        scl, sda, start, stop, rise, fall;

  smb_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .scl_i   (bus.scl),
    .sda_i   (bus.sda),
    .scl_o   (scl),
    .sda_o   (sda),
    .start_o (start),
    .stop_o  (stop),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  wire [6:0] strap_addr  = address_strap_enable_pin_i ?
                           smb_pkg::ADDR_STRAP_HIGH :
                           {smb_pkg::ADDR_HIGH_PART, 1'b0,
                            address_select_strap_pin_i};
  wire [6:0] my_addr     = addr_set_q ? addr_q : strap_addr;
  wire       alert_act   = |(status_i & ~mask_i);
  wire [6:0] rx_addr     = shift_q[7:1];
  wire       hit_own     = rx_addr == my_addr;
  wire       hit_ara     = alert_act & shift_q[0] &
                           (rx_addr == smb_pkg::ALERT_RESP_ADDR);
  wire       is_read     = shift_q[0];
  wire       byte_done   = bit_q == 4'd8;
  wire       to_enable   = ~cfg1_q[smb_pkg::BUS_TIMEOUT_DISABLE_BIT];
  wire       timed_out   = to_enable & (state_q != ST_IDLE) &
                           (idle_q >= TIMEOUT_CYC);
  wire [7:0] tx_byte     = ara_q ? {my_addr, 1'b1} :
                           ((ptr_q == smb_pkg::CFG1_OFFSET) ? cfg1_q :
                            reg_rdata_i);
  wire [2:0] tx_idx      = 3'(7 - bit_q[2:0]);
  // Ack slots must not shift in, or the R/W bit is lost
  wire       in_ack      = (state_q == ST_AACK) | (state_q == ST_WACK);

  assign reg_addr_o    = ptr_q;
  assign reg_wdata_o   = wdata_q;
  assign reg_we_o      = we_q;
  assign cfg1_o        = cfg1_q;
  assign alert_n_o     = ~alert_act;
  assign dev_addr_o    = my_addr;
  assign bus.sda_dev_o  = 1'b0;
  assign bus.sda_dev_oe = sda_oe_q;
  assign status_read_o  = (state_q == ST_RD) & fall & byte_done & ~ara_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: state_d = ST_IDLE;
      ST_ADDR: if (fall && byte_done) begin
        state_d = (hit_own || hit_ara) ? ST_AACK : ST_IDLE;
      end
      ST_AACK: if (fall) begin
        state_d = is_read ? ST_RD : ST_WR;
      end
      ST_WR:   if (fall && byte_done) state_d = ST_WACK;
      ST_WACK: if (fall) state_d = ST_WR;
      ST_RD:   if (fall && byte_done) state_d = ST_RACK;
      ST_RACK: if (rise) state_d = ST_IDLE;   // one byte per read
      default: state_d = ST_IDLE;
    endcase
    if (start) state_d = ST_ADDR;
    if (stop || timed_out) state_d = ST_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      idle_q  <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
      if (start || stop || rise || fall || state_q == ST_IDLE) begin
        idle_q <= '0;
      end else if (!timed_out) begin
        idle_q <= idle_q + 32'd1;
      end
    end
  end

  // Bit counter and shifter; sampling on the rising clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_q   <= '0;
      shift_q <= '0;
    end else if (ce_i) begin
      if (start || (fall && (byte_done || state_q == ST_AACK ||
                             state_q == ST_WACK))) begin
        bit_q <= '0;
      end else if (rise && !byte_done && !in_ack) begin
        bit_q   <= bit_q + 4'd1;
        shift_q <= {shift_q[6:0], sda};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q      <= '0;
      cfg1_q     <= smb_pkg::CFG1_RESET;
      addr_q     <= '0;
      addr_set_q <= 1'b0;
      wr_cnt_q   <= 1'b0;
      ara_q      <= 1'b0;
      we_q       <= 1'b0;
      wdata_q    <= '0;
    end else if (ce_i) begin
      we_q <= 1'b0;
      if (state_q == ST_ADDR && fall && byte_done) begin
        wr_cnt_q <= 1'b0;
        ara_q    <= hit_ara & ~hit_own;
        if (!addr_set_q) begin
          addr_q     <= strap_addr;
          addr_set_q <= 1'b1;
        end
      end
      if (state_q == ST_WR && fall && byte_done) begin
        if (!wr_cnt_q) begin
          ptr_q    <= shift_q;
          wr_cnt_q <= 1'b1;
        end else begin
          wdata_q <= shift_q;
          we_q    <= 1'b1;
          if (ptr_q == smb_pkg::CFG1_OFFSET) begin
            cfg1_q <= shift_q;
          end
        end
      end
    end
  end

  // Data line drive: acks and read bits, with arbitration on alert response reads only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_oe_q <= 1'b0;
      lost_q   <= 1'b0;
    end else if (ce_i) begin
      if (stop || start || timed_out) begin
        sda_oe_q <= 1'b0;
        lost_q   <= 1'b0;
      end else if (fall) begin
        if (state_q == ST_ADDR && byte_done) begin
          sda_oe_q <= hit_own | hit_ara;
          lost_q   <= 1'b0;
        end else if (state_q == ST_WR && byte_done) begin
          sda_oe_q <= 1'b1;
        end else if ((state_q == ST_AACK && is_read) ||
                     (state_q == ST_RD && !byte_done)) begin
          sda_oe_q <= ~lost_q & ~tx_byte[tx_idx];
        end else begin
          sda_oe_q <= 1'b0;
        end
      end else if (rise && state_q == ST_RD && ara_q &&
                   !sda_oe_q && !sda) begin
        lost_q   <= 1'b1;
      end
    end
  end
endmodule

/* File: include/smb_pkg.sv */
package smb_pkg;
  // Device slave address parts
  localparam logic [4:0] ADDR_HIGH_PART  = 5'h0B;   // 01011
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h2E;   // 0101110
  localparam logic [6:0] ADDR_SEL_LOW    = 7'h2C;   // 0101100
  localparam logic [6:0] ADDR_SEL_HIGH   = 7'h2D;   // 0101101
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;   // 0001100
  // Register map of the device
  localparam logic [7:0] CFG1_OFFSET     = 8'h40;
  localparam logic [7:0] CFG1_RESET      = 8'h00;
  localparam int         BUS_TIMEOUT_DISABLE_BIT       = 6;
  localparam int         ALERT_BITS      = 8;
  // Timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int TIMEOUT_MIN_MS = 15;
  localparam int TIMEOUT_MAX_MS = 35;
  // Least time rounds up; chosen at the lower bound
  localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MIN_MS;
  localparam int LINK_DIV       = 4;     // Master quarter-period (one phase) in clk cycles
  localparam int BYTE_BITS      = 8;
  // Host command register offsets (designer's own)
  localparam logic [3:0] HOST_CTRL   = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h4;
  localparam logic [3:0] HOST_DATA   = 4'h8;
  // Host operation codes
  typedef enum logic [1:0] {
    SMB_OP_SEND    = 2'b00,
    SMB_OP_WRITE   = 2'b01,
    SMB_OP_RECEIVE = 2'b10,
    SMB_OP_READ    = 2'b11
  } smb_op_type;
endpackage

/* File: include/smb_if.sv */
`timescale 1ns/1ns
interface smb_if;
  logic scl_o;
  logic scl_oe;
  logic sda_dev_oe;
  logic sda_host_oe;
  logic sda_host_o;
  logic sda_dev_o;
  wire  scl   = ~scl_oe;
  wire  sda   = ~(sda_dev_oe | sda_host_oe);
  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe,
                output sda_host_o, output sda_host_oe);
endinterface

/* File: hw/smb_sync.sv */
`timescale 1ns/1ns
module smb_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      start_o,
  output logic      stop_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;
  // Edges taken on the second stage only
  assign scl_o   = scl_sync_q[1];
  assign sda_o   = sda_sync_q[1];
  assign rise_o  = scl_o & ~scl_q;
  assign fall_o  = ~scl_o & scl_q;
  assign start_o = scl_o & scl_q & sda_q & ~sda_o;
  assign stop_o  = scl_o & scl_q & ~sda_q & sda_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else if (ce_i) begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end
endmodule

/* File: hw/smb_host.sv */
`timescale 1ns/1ns
module smb_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  smb_if.host              bus,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN  = 2'b01
  } smb_host_state_type;

  // Bit program: each slot is one SCL period on the line
  smb_host_state_type state_q;
  logic [6:0]  addr_q;
  logic [7:0]  cmd_q, data_q, rx_q;
  logic [1:0]  op_q;
  logic        nack_q, busy_q, ack_q;
  logic        rs_done_q;
  logic [6:0]  slot_q;
  logic [1:0]  phase_q;
  logic [7:0]  div_q;
  logic        scl_q, sda_q;
  logic [1:0]  sda_sync_q;

  wire req      = cyc_i & stb_i & ~ack_q;
  wire wr_ctrl  = req & we_i & (adr_i == smb_pkg::HOST_CTRL) & sel_i[0];
  wire wr_data  = req & we_i & (adr_i == smb_pkg::HOST_DATA) & sel_i[0];
  wire go       = wr_ctrl & dat_i[31] & ~busy_q;
  wire tick     = div_q == 8'(smb_pkg::LINK_DIV - 1);
  wire is_rd    = op_q[1];
  wire two_b    = op_q == smb_pkg::SMB_OP_WRITE;
  wire rs_read  = op_q == smb_pkg::SMB_OP_READ;
  // Byte list: addr, [cmd], [data] or repeated start + addr|R, rx
  wire [3:0] n_bytes = rs_read ? 4'd4 : (two_b ? 4'd3 : 4'd2);
  wire [3:0] byte_i  = 4'(slot_q / 7'd9);
  wire [3:0] bit_i   = 4'(slot_q % 7'd9);
  wire       rx_byte = is_rd & (byte_i == n_bytes - 4'd1);
  wire [7:0] cur_byte = (byte_i == 4'd0) ?
                        {addr_q, op_q == smb_pkg::SMB_OP_RECEIVE} :
                        (rs_read && byte_i == 4'd1) ? cmd_q :
                        (rs_read) ? {addr_q, 1'b1} :
                        (byte_i == 4'd1) ? cmd_q : data_q;
  // Ack slots released: slave acks, or our NACK on the read byte
  wire       drive_bit = (bit_i == 4'd8 || rx_byte) ? 1'b1 :
                         cur_byte[3'(7 - bit_i[2:0])];
  wire       rs_pend   = rs_read & (slot_q == 7'd18) & ~rs_done_q;

  assign ack_o           = ack_q;
  assign bus.scl_o       = 1'b0;
  assign bus.scl_oe      = ~scl_q;
  assign bus.sda_host_o  = 1'b0;
  assign bus.sda_host_oe = ~sda_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= '0;
      addr_q <= '0;
      cmd_q <= '0;
      data_q <= '0;
      op_q <= smb_pkg::SMB_OP_SEND;
    end else if (ce_i) begin
      ack_q <= req;
      if (req && !we_i) begin
        dat_o <= (adr_i == smb_pkg::HOST_STATUS) ?
                 {30'h0000_0000, nack_q, busy_q} :
                 (adr_i == smb_pkg::HOST_DATA) ? {24'h00_0000, rx_q} :
                 32'h0000_0000;
      end
      if (go) begin
        addr_q <= dat_i[22:16];
        op_q   <= dat_i[25:24];
        cmd_q  <= dat_i[15:8];
      end
      if (wr_data) data_q <= dat_i[7:0];
    end
  end

  // Four phases per slot: fall, low/set, rise, high/sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= HS_IDLE;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      rs_done_q <= 1'b0;
      rx_q <= '0;
      slot_q <= '0;
      phase_q <= '0;
      div_q <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_sync_q <= 2'b11;
    end else if (ce_i) begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      if (state_q == HS_IDLE) begin
        if (go) begin
          state_q <= HS_RUN;
          busy_q  <= 1'b1;
          nack_q  <= 1'b0;
          rs_done_q <= 1'b0;
          slot_q  <= '0;
          phase_q <= '0;
          sda_q   <= 1'b0;          // Start: data falls, clock high
        end
      end else if (tick) begin
        phase_q <= phase_q + 2'd1;
        unique case (phase_q)
          2'd0: begin
            scl_q <= 1'b0;
          end
          2'd1: begin
            sda_q <= rs_pend ? 1'b1 :
                     (slot_q == 7'(n_bytes * 9)) ? 1'b0 : drive_bit;
          end
          2'd2: begin
            scl_q <= 1'b1;
          end
          2'd3: begin
            if (rs_pend) begin
              // Extra slot: data falls with clock high, slot count kept
              sda_q     <= 1'b0;
              rs_done_q <= 1'b1;
            end else if (slot_q == 7'(n_bytes * 9)) begin
              sda_q   <= 1'b1;
              state_q <= HS_IDLE;
              busy_q  <= 1'b0;
            end else begin
              if (bit_i == 4'd8 && !rx_byte && sda_sync_q[1]) begin
                nack_q <= 1'b1;
              end
              if (rx_byte && bit_i < 4'd8) begin
                rx_q <= {rx_q[6:0], sda_sync_q[1]};
              end
              slot_q <= slot_q + 7'd1;
            end
          end
        endcase
      end
    end
  end
endmodule

/* File: dv/smb_checker.sv */
`timescale 1ns/1ns
module smb_checker #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_oe,
  input wire logic sda_dev_oe,
  input wire logic sda_host_oe,
  input wire logic scl,
  input wire logic sda
);
  logic        scl_q;
  logic        sda_q;
  logic        rd_q;
  logic [7:0]  cnt_q;
  logic [31:0] hold_q;
  wire         hi_w    = scl && scl_q;
  wire         rise_w  = scl && !scl_q;
  wire         start_w = hi_w && sda_q && !sda;
  wire         stop_w  = hi_w && !sda_q && sda;
  wire [7:0]   slot_w  = cnt_q % 8'h09;
  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    rd_q  <= (rise_w && cnt_q == 8'h07) ? sda : rd_q;
  end
  // Clock rises since the last start or stop
  always_ff @(posedge clk_i) begin
    if (rst_i || start_w || stop_w) begin
      cnt_q <= 8'h00;
    end else if (rise_w) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Device holds data low with a frozen clock: a stuck bus
  always_ff @(posedge clk_i) begin
    if (rst_i || !sda_dev_oe || scl != scl_q) begin
      hold_q <= 32'h0000_0000;
    end else begin
      hold_q <= hold_q + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  dev_sda_stable_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device data moved with clock high");
  frame_edge_a: assert property (
    hi_w && sda != sda_q |-> cnt_q == 8'h00 || slot_w == 8'h01)
    else $error("start or stop away from a byte boundary");
  addr_listen_a: assert property (
    hi_w && cnt_q != 8'h00 && cnt_q <= 8'h08 |-> !sda_dev_oe)
    else $error("device drove data during address byte");
  dir_fixed_a: assert property (
    hi_w && sda_dev_oe && cnt_q > 8'h08 |-> slot_w == 8'h00 || rd_q)
    else $error("device drove data in a write");
  host_ack_free_a: assert property (
    hi_w && slot_w == 8'h00 && cnt_q != 8'h00 && (!rd_q || cnt_q == 8'h09)
    |-> !sda_host_oe)
    else $error("host drove data in device ack slot");
  rd_master_ack_a: assert property (
    hi_w && rd_q && cnt_q > 8'h09 && slot_w == 8'h00 |-> !sda_dev_oe)
    else $error("device drove data in host ack slot");
  start_free_a: assert property (start_w |-> !sda_dev_oe && sda_host_oe)
    else $error("start while device drives data");
  scl_low_len_a: assert property ($rose(scl_oe) |-> scl_oe [*4])
    else $error("clock low phase too short");
  scl_high_len_a: assert property ($fell(scl_oe) |-> !scl_oe [*4])
    else $error("clock high phase too short");
  timeout_bound_a: assert property (hold_q < 32'(TIMEOUT_CYC + 32))
    else $error("device kept the bus past the timeout");
endmodule

/* File: dv/smb_tb_top.sv */
`timescale 1ns/1ns
module smb_slave_register_access_tb_top;
  localparam int TO_CYC = 200;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        sen = 1'b1;
  logic        ssel = 1'b0;
  logic [7:0]  status = 8'h00;
  logic [7:0]  mask = 8'h00;
  logic [7:0]  raddr;
  logic [7:0]  rwd;
  logic        rwe;
  logic [7:0]  cfg1;
  logic        alert_n;
  logic [6:0]  daddr;
  logic [6:0]  daddr2;
  logic        srd;
  int          nsrd = 0;
  logic [7:0]  mem [256];
  logic [7:0]  exp_mem [256];
  int          miscompares = 0;
  int          checks = 0;
  smb_if bus_m ();
  smb_if bus_t ();
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (rwe) mem[raddr] <= rwd;
  always @(posedge clk_i) if (srd) nsrd <= nsrd + 1;
  smb_host u_smb_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .bus(bus_m), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack));
  smb_dev #(.TIMEOUT_CYC(TO_CYC)) u_smb_dev (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(1'b1), .bus(bus_m),
    .address_strap_enable_pin_i(sen), .address_select_strap_pin_i(ssel),
    .reg_rdata_i(mem[raddr]), .reg_addr_o(raddr), .reg_wdata_o(rwd),
    .reg_we_o(rwe), .status_i(status), .mask_i(mask),
    .status_read_o(srd), .cfg1_o(cfg1), .alert_n_o(alert_n),
    .dev_addr_o(daddr));
  // Second device faces a hand-driven master that stalls mid-read
  smb_dev #(.TIMEOUT_CYC(TO_CYC)) u_smb_dev_2 (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(1'b1), .bus(bus_t),
    .address_strap_enable_pin_i(1'b0), .address_select_strap_pin_i(1'b0),
    .reg_rdata_i(8'h00), .reg_addr_o(), .reg_wdata_o(), .reg_we_o(),
    .status_i(status), .mask_i(mask), .status_read_o(), .cfg1_o(),
    .alert_n_o(), .dev_addr_o(daddr2));
  smb_checker #(.TIMEOUT_CYC(TO_CYC)) u_smb_checker (.clk_i(clk_i),
    .rst_i(rst_i), .scl_oe(bus_m.scl_oe), .sda_dev_oe(bus_m.sda_dev_oe),
    .sda_host_oe(bus_m.sda_host_oe), .scl(bus_m.scl), .sda(bus_m.sda));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [6:0] exp_addr(input logic en, input logic sl);
    return en ? smb_pkg::ADDR_STRAP_HIGH :
                (sl ? smb_pkg::ADDR_SEL_HIGH : smb_pkg::ADDR_SEL_LOW);
  endfunction

  task automatic tally_and_finish();
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 100) begin
      miscompares++;
      tally_and_finish();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic smb_op(input smb_pkg::smb_op_type op, input logic [6:0] a,
                        input logic [7:0] c, input logic [7:0] d,
                        output logic [7:0] rd, output logic nk);
    logic [31:0] q;
    int n;
    n = 0;
    wb(1'b1, smb_pkg::HOST_DATA, {24'h00_0000, d}, q);
    wb(1'b1, smb_pkg::HOST_CTRL, {1'b1, 5'h00, op, 1'b0, a, c, 8'h00}, q);
    q = 32'h0000_0001;
    while (q[0] !== 1'b0 && n < 1000) begin
      n++;
      wb(1'b0, smb_pkg::HOST_STATUS, 32'h0000_0000, q);
    end
    if (n == 1000) begin
      miscompares++;
      tally_and_finish();
    end
    nk = q[1];
    wb(1'b0, smb_pkg::HOST_DATA, 32'h0000_0000, q);
    rd = q[7:0];
  endtask

  task automatic bb(input logic b, output logic s);
    repeat (2) @(posedge clk_i);
    bus_t.sda_host_oe <= !b;
    repeat (4) @(posedge clk_i);
    bus_t.scl_oe <= 1'b0;
    repeat (4) @(posedge clk_i);
    s = bus_t.sda;
    bus_t.scl_oe <= 1'b1;
  endtask

  initial begin
    repeat (80000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] b8;
    logic       nk;
    logic       s;
    bus_t.scl_oe = 1'b0;
    bus_t.scl_o = 1'b0;
    bus_t.sda_host_oe = 1'b0;
    bus_t.sda_host_o = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    for (int i = 0; i < 256; i++) exp_mem[i] = 8'h00;
    void'($urandom(32'hc57a));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(cfg1, smb_pkg::CFG1_RESET);
    chk(alert_n, 1'b1);
    chk({bus_m.scl, bus_m.sda}, 2'b11);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'h00 : 8'($urandom_range(62));
      d = (i == 0) ? 8'hff : 8'($urandom);
      exp_mem[a] = d;
      smb_op(smb_pkg::SMB_OP_WRITE, smb_pkg::ADDR_STRAP_HIGH, a, d, r, nk);
      chk(nk, 1'b0);
      chk(mem[a], d);
      smb_op(smb_pkg::SMB_OP_SEND, smb_pkg::ADDR_STRAP_HIGH, a + 8'h01,
             8'h00, r, nk);
      chk(nk, 1'b0);
      chk(raddr, a + 8'h01);
      smb_op(smb_pkg::SMB_OP_RECEIVE, smb_pkg::ADDR_STRAP_HIGH, 8'h00,
             8'h00, r, nk);
      chk(r, exp_mem[a + 8'h01]);
      smb_op(smb_pkg::SMB_OP_READ, smb_pkg::ADDR_STRAP_HIGH, a, 8'h00, r, nk);
      chk(r, d);
    end
    chk(nsrd, 32'd12);
    // Straps move after the address was taken
    sen <= 1'b0;
    ssel <= 1'b1;
    smb_op(smb_pkg::SMB_OP_SEND, smb_pkg::ADDR_STRAP_HIGH, 8'h05, 8'h00, r, nk);
    chk(nk, 1'b0);
    chk(daddr, smb_pkg::ADDR_STRAP_HIGH);
    smb_op(smb_pkg::SMB_OP_WRITE, smb_pkg::ADDR_SEL_LOW, 8'h07, 8'h5a, r, nk);
    chk(nk, 1'b1);
    chk(raddr, 8'h05);
    smb_op(smb_pkg::SMB_OP_RECEIVE, smb_pkg::ALERT_RESP_ADDR, 8'h00, 8'h00,
           r, nk);
    chk(nk, 1'b1);
    status <= 8'h81;
    mask <= 8'h81;
    @(posedge clk_i);
    chk(alert_n, 1'b1);
    mask <= 8'h01;
    @(posedge clk_i);
    chk(alert_n, 1'b0);
    smb_op(smb_pkg::SMB_OP_RECEIVE, smb_pkg::ALERT_RESP_ADDR, 8'h00, 8'h00,
           r, nk);
    chk(nk, 1'b0);
    chk(r, {smb_pkg::ADDR_STRAP_HIGH, 1'b1});
    status <= 8'h00;
    @(posedge clk_i);
    chk(alert_n, 1'b1);
    smb_op(smb_pkg::SMB_OP_WRITE, smb_pkg::ADDR_STRAP_HIGH,
           smb_pkg::CFG1_OFFSET, 8'h40, r, nk);
    chk(cfg1, 8'h40);
    // Read from the second device, then freeze the clock low after the address ack, before the first read bit
    b8 = {smb_pkg::ADDR_SEL_LOW, 1'b1};
    bus_t.sda_host_oe <= 1'b1;
    repeat (4) @(posedge clk_i);
    bus_t.scl_oe <= 1'b1;
    for (int i = 7; i >= 0; i--) bb(b8[i], s);
    bb(1'b1, s);
    chk(s, 1'b0);
    repeat (20) @(posedge clk_i);
    chk(bus_t.sda_dev_oe, 1'b1);
    repeat (480) @(posedge clk_i);
    chk(bus_t.sda_dev_oe, 1'b0);
    chk(daddr2, exp_addr(1'b0, 1'b0));
    bus_t.scl_oe <= 1'b0;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    smb_op(smb_pkg::SMB_OP_WRITE, smb_pkg::ADDR_SEL_HIGH, 8'h11, 8'h22, r, nk);
    chk(nk, 1'b0);
    chk(daddr, exp_addr(sen, ssel));
    tally_and_finish();
  end
endmodule
